// *** rtl/phv_top.v ***
// PCM highway port: serial word timing, signaling, law and loopback.
// Assumes APB master on ref_clk; all highway pins asynchronous to it.
`timescale 1ns/1ps
`include "phv_defines.vh"

module phv_top (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        srst,
  // APB slave
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Highway clocks and strobes
  input  wire        tx_bit_clock,
  input  wire        rx_bit_clock,
  input  wire        tx_master_clock,
  input  wire        rx_master_clock,
  input  wire        tx_frame_strobe,
  input  wire        rx_frame_strobe,
  // Highway data
  input  wire        pcm_in,
  output reg         pcm_out,
  output reg         pcm_out_oe,
  output reg         tx_slot_active_n,
  output reg         tx_slot_active_oe,
  // Signaling and straps
  input  wire        tx_signaling_input,
  output reg         rx_signaling_output,
  input  wire        loopback_control,
  input  wire        law_select_neg
);

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  function [7:0] law_mask;
    input a_law;
    begin
      law_mask = a_law ? `PHV_MASK_A_LAW : `PHV_MASK_MU_LAW;
    end
  endfunction

  // Signed difference to sign-magnitude code, sign 1 = positive
  function [7:0] enc_code;
    input [8:0] d;
    reg   [8:0] mag;
    begin
      mag = d[8] ? (9'h000 - d) : d;
      mag = (mag > 9'h07F) ? 9'h07F : mag;
      enc_code = {~d[8], mag[6:0]};
    end
  endfunction

  function [7:0] dec_code;
    input [7:0] c;
    begin
      dec_code = c[7] ? {1'b0, c[6:0]} : (8'h00 - {1'b0, c[6:0]});
    end
  endfunction

  // ------------------------------------------------------------
  // Pin synchronisation
  // ------------------------------------------------------------
  wire [`PHV_SYNC_W-1:0] pin_raw;
  wire [`PHV_SYNC_W-1:0] pin_lvl;
  wire [`PHV_SYNC_W-1:0] pin_rise;
  wire [`PHV_SYNC_W-1:0] pin_fall;

  assign pin_raw = {pcm_in, law_select_neg, loopback_control, tx_signaling_input,
                    rx_frame_strobe, tx_frame_strobe, rx_master_clock,
                    tx_master_clock, rx_bit_clock, tx_bit_clock};

  phv_sync #(
    .W (`PHV_SYNC_W)
  ) u_sync (
    .clk  (ref_clk),
    .srst (srst),
    .din  (pin_raw),
    .lvl  (pin_lvl),
    .rise (pin_rise),
    .fall (pin_fall)
  );

  wire tx_fs     = pin_lvl[`PHV_IN_TX_FS];
  wire rx_fs     = pin_lvl[`PHV_IN_RX_FS];
  wire tx_fs_up  = pin_rise[`PHV_IN_TX_FS];
  wire rx_fs_up  = pin_rise[`PHV_IN_RX_FS];
  wire a_law     = pin_lvl[`PHV_IN_LAW];
  wire loop_on   = pin_lvl[`PHV_IN_LOOP];
  wire pcm_bit   = pin_lvl[`PHV_IN_PCM];
  wire rx_b_edge = pin_rise[`PHV_IN_RX_BCLK] | pin_fall[`PHV_IN_RX_BCLK];

  // ------------------------------------------------------------
  // Registers and state
  // ------------------------------------------------------------
  reg  [1:0]  ctrl_reg;
  reg  [7:0]  tx_sample_reg;
  reg  [11:0] mode_cnt_reg;
  reg         var_mode_reg;
  reg  [7:0]  held_reg;
  reg  [7:0]  tx_word_reg;
  reg  [2:0]  tx_cnt_reg;
  reg         tx_arm_reg;
  reg  [1:0]  tx_wid_reg;
  reg         tx_sigf_reg;
  reg  [6:0]  rx_shift_reg;
  reg  [2:0]  rx_cnt_reg;
  reg         rx_arm_reg;
  reg  [1:0]  rx_wid_reg;
  reg         rx_sigf_reg;
  reg  [7:0]  rx_code_reg;
  reg  [7:0]  rx_lin_reg;
  reg         rx_new_reg;
  wire [3:0]  az_offset;

  // ------------------------------------------------------------
  // Timing mode detection
  // ------------------------------------------------------------
  // A tied receive bit clock never toggles; timeout exceeds a 64 kHz half period
  always @(posedge ref_clk) begin
    if (srst) begin
      mode_cnt_reg <= 12'h000;
      var_mode_reg <= 1'b0;
    end else if (rx_b_edge) begin
      mode_cnt_reg <= 12'h000;
      var_mode_reg <= 1'b1;
    end else if (mode_cnt_reg != `PHV_MODE_TMO_CYC) begin
      mode_cnt_reg <= mode_cnt_reg + 12'h001;
    end else begin
      var_mode_reg <= 1'b0;
    end
  end

  // Shift edges follow bit clocks in variable mode, master clocks otherwise
  wire tx_mclk_up = pin_rise[`PHV_IN_TX_MCLK];
  wire rx_mclk_up = pin_rise[`PHV_IN_RX_MCLK];
  wire tx_edge = var_mode_reg ? pin_rise[`PHV_IN_TX_BCLK] : tx_mclk_up;
  wire rx_edge = var_mode_reg ? pin_fall[`PHV_IN_RX_BCLK] : pin_fall[`PHV_IN_RX_MCLK];

  // ------------------------------------------------------------
  // Encoder path
  // ------------------------------------------------------------
  wire [8:0] enc_diff = {held_reg[7], held_reg} - {{5{az_offset[3]}}, az_offset};
  wire [7:0] enc_raw  = enc_code(enc_diff);
  wire [7:0] enc_line = enc_raw ^ law_mask(a_law);

  phv_autozero u_autozero (
    .clk      (ref_clk),
    .srst     (srst),
    .upd      (tx_fs_up),
    .sign_pos (enc_raw[7]),
    .offset   (az_offset)
  );

  // Sample caught at one frame start goes out at the next
  always @(posedge ref_clk) begin
    if (srst) begin
      held_reg    <= 8'h00;
      tx_word_reg <= 8'h00;
    end else if (tx_fs_up) begin
      held_reg    <= loop_on ? rx_lin_reg : tx_sample_reg;
      tx_word_reg <= enc_line;
    end
  end

  // ------------------------------------------------------------
  // Transmit shifter
  // ------------------------------------------------------------
  wire tx_sig_now = !var_mode_reg && !a_law && (tx_wid_reg == 2'h2);
  wire tx_go = ctrl_reg[`PHV_CTRL_TX_EN] && (var_mode_reg ? tx_fs : tx_arm_reg);
  wire [7:0] tx_src = tx_fs_up ? enc_line : tx_word_reg;
  wire tx_bit_d = (tx_cnt_reg == 3'h7) ? (tx_sig_now ? pin_lvl[`PHV_IN_TX_SIG]
                                                     : tx_src[0])
                                       : tx_src[3'h7 - tx_cnt_reg];

  always @(posedge ref_clk) begin
    if (srst) begin
      tx_wid_reg  <= 2'h0;
      tx_arm_reg  <= 1'b0;
      tx_sigf_reg <= 1'b0;
    end else begin
      if (tx_fs_up) begin
        tx_wid_reg <= 2'h0;
      end else if (tx_mclk_up && tx_fs && tx_wid_reg != 2'h2) begin
        tx_wid_reg <= tx_wid_reg + 2'h1;
      end
      if (tx_fs_up && !var_mode_reg) begin
        tx_arm_reg <= 1'b1;
      end else if (tx_edge && tx_go && tx_cnt_reg == 3'h7) begin
        tx_arm_reg  <= 1'b0;
        tx_sigf_reg <= tx_sig_now;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      tx_cnt_reg        <= 3'h0;
      pcm_out           <= 1'b0;
      pcm_out_oe        <= 1'b0;
      tx_slot_active_n  <= 1'b1;
      tx_slot_active_oe <= 1'b0;
    end else if (tx_edge) begin
      if (tx_go) begin
        pcm_out           <= tx_bit_d;
        pcm_out_oe        <= 1'b1;
        tx_slot_active_n  <= 1'b0;
        tx_slot_active_oe <= 1'b1;
        tx_cnt_reg        <= tx_cnt_reg + 3'h1;
      end else begin
        tx_cnt_reg        <= 3'h0;
        pcm_out_oe        <= 1'b0;
        tx_slot_active_n  <= 1'b1;
        tx_slot_active_oe <= 1'b0;
      end
    end else if (var_mode_reg && !tx_fs) begin
      tx_cnt_reg        <= 3'h0;
      pcm_out_oe        <= 1'b0;
      tx_slot_active_n  <= 1'b1;
      tx_slot_active_oe <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Receive shifter
  // ------------------------------------------------------------
  wire rx_sig_now = !var_mode_reg && !a_law && (rx_wid_reg == 2'h2);
  wire rx_go = ctrl_reg[`PHV_CTRL_RX_EN] && rx_arm_reg && (!var_mode_reg || rx_fs);
  wire rx_done = rx_edge && rx_go && (rx_cnt_reg == 3'h7);
  wire [7:0] rx_full = {rx_shift_reg, pcm_bit};
  wire [7:0] rx_voice = rx_sig_now ? {rx_full[7:1], 1'b0} : rx_full;
  wire rx_data_rd;

  always @(posedge ref_clk) begin
    if (srst) begin
      rx_wid_reg <= 2'h0;
      rx_arm_reg <= 1'b0;
      rx_cnt_reg <= 3'h0;
      rx_shift_reg <= 7'h00;
    end else begin
      if (rx_fs_up) begin
        rx_wid_reg <= 2'h0;
      end else if (rx_mclk_up && rx_fs && rx_wid_reg != 2'h2) begin
        rx_wid_reg <= rx_wid_reg + 2'h1;
      end
      if (rx_fs_up) begin
        rx_arm_reg <= 1'b1;
        rx_cnt_reg <= 3'h0;
      end else if (var_mode_reg && !rx_fs) begin
        rx_arm_reg <= 1'b0;
        rx_cnt_reg <= 3'h0;
      end else if (rx_edge && rx_go) begin
        rx_shift_reg <= rx_full[6:0];
        rx_cnt_reg   <= rx_cnt_reg + 3'h1;
        if (rx_cnt_reg == 3'h7) begin
          rx_arm_reg <= 1'b0;
        end
      end
    end
  end

  // Signaling output holds until the next receive signaling frame
  always @(posedge ref_clk) begin
    if (srst) begin
      rx_code_reg         <= 8'h00;
      rx_lin_reg          <= 8'h00;
      rx_sigf_reg         <= 1'b0;
      rx_signaling_output <= 1'b0;
      rx_new_reg          <= 1'b0;
    end else begin
      if (rx_done) begin
        rx_code_reg <= rx_voice;
        rx_lin_reg  <= dec_code(rx_voice ^ law_mask(a_law));
        rx_sigf_reg <= rx_sig_now;
        if (rx_sig_now) begin
          rx_signaling_output <= rx_full[0];
        end
      end
      // A word landing on the clearing read stays flagged
      rx_new_reg <= rx_done | (rx_new_reg & ~rx_data_rd);
    end
  end

  // ------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------
  wire apb_setup  = psel && !penable;
  wire apb_access = psel && penable && pready;
  wire ofs_ok = (paddr == `PHV_OFS_CTRL) || (paddr == `PHV_OFS_TX_SAMPLE) ||
                (paddr == `PHV_OFS_RX_DATA) || (paddr == `PHV_OFS_STATUS);
  assign rx_data_rd = apb_access && !pwrite && (paddr == `PHV_OFS_RX_DATA);

  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    case (paddr)
      `PHV_OFS_CTRL:      rd_mux[1:0] = ctrl_reg;
      `PHV_OFS_TX_SAMPLE: rd_mux[7:0] = tx_sample_reg;
      `PHV_OFS_RX_DATA:   rd_mux[15:0] = {rx_lin_reg, rx_code_reg};
      `PHV_OFS_STATUS: begin
        rd_mux[`PHV_ST_VAR_MODE] = var_mode_reg;
        rd_mux[`PHV_ST_A_LAW]    = a_law;
        rd_mux[`PHV_ST_LOOP]     = loop_on;
        rd_mux[`PHV_ST_RX_SIG]   = rx_signaling_output;
        rd_mux[`PHV_ST_TX_SIGF]  = tx_sigf_reg;
        rd_mux[`PHV_ST_RX_SIGF]  = rx_sigf_reg;
        rd_mux[`PHV_ST_RX_NEW]   = rx_new_reg;
        rd_mux[`PHV_ST_OFS_HI:`PHV_ST_OFS_LO] = az_offset;
      end
      default:            rd_mux = 32'h00000000;
    endcase
  end

  // Zero-wait answer: ready is raised for the access cycle only
  always @(posedge ref_clk) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= apb_setup;
      pslverr <= apb_setup && !ofs_ok;
      if (apb_setup) begin
        prdata <= (!pwrite && ofs_ok) ? rd_mux : 32'h00000000;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      ctrl_reg      <= `PHV_CTRL_RESET;
      tx_sample_reg <= `PHV_TX_SAMPLE_RST;
    end else if (apb_access && pwrite && pstrb[0]) begin
      if (paddr == `PHV_OFS_CTRL) begin
        ctrl_reg <= pwdata[1:0];
      end
      if (paddr == `PHV_OFS_TX_SAMPLE) begin
        tx_sample_reg <= pwdata[7:0];
      end
    end
  end

endmodule // phv_top

// *** rtl/phv_defines.vh ***
// Constants for the PCM highway variable-rate port.
// Assumes inclusion by bare name from every design file of the port.
`ifndef PHV_DEFINES_VH
`define PHV_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define PHV_OFS_CTRL       8'h00
`define PHV_OFS_TX_SAMPLE  8'h04
`define PHV_OFS_RX_DATA    8'h08
`define PHV_OFS_STATUS     8'h0C

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define PHV_CTRL_TX_EN     0
`define PHV_CTRL_RX_EN     1
`define PHV_CTRL_RESET     2'h3
`define PHV_TX_SAMPLE_RST  8'h00
`define PHV_ST_VAR_MODE    0
`define PHV_ST_A_LAW       1
`define PHV_ST_LOOP        2
`define PHV_ST_RX_SIG      3
`define PHV_ST_TX_SIGF     4
`define PHV_ST_RX_SIGF     5
`define PHV_ST_RX_NEW      6
`define PHV_ST_OFS_LO      8
`define PHV_ST_OFS_HI      11

// ----------------------------------------------------------------
// Synchroniser lanes
// ----------------------------------------------------------------
`define PHV_SYNC_W         10
`define PHV_IN_TX_BCLK     0
`define PHV_IN_RX_BCLK     1
`define PHV_IN_TX_MCLK     2
`define PHV_IN_RX_MCLK     3
`define PHV_IN_TX_FS       4
`define PHV_IN_RX_FS       5
`define PHV_IN_TX_SIG      6
`define PHV_IN_LOOP        7
`define PHV_IN_LAW         8
`define PHV_IN_PCM         9

// ----------------------------------------------------------------
// Line coding and timing
// ----------------------------------------------------------------
`define PHV_MASK_A_LAW     8'h55
`define PHV_MASK_MU_LAW    8'hFF
`define PHV_CLK_PERIOD_NS  8
`define PHV_MODE_TMO_NS    20000
`define PHV_MODE_TMO_CYC   (`PHV_MODE_TMO_NS / `PHV_CLK_PERIOD_NS)
`define PHV_AZ_SHIFT       8

`endif

// *** rtl/phv_sync.v ***
// Two-flop synchroniser bank with edge detection on the settled stage.
// Assumes asynchronous pin levels and a synchronous active-high reset.
`timescale 1ns/1ps
`include "phv_defines.vh"

module phv_sync #(
  parameter W = `PHV_SYNC_W
) (
  // Clock and reset
  input  wire         clk,
  input  wire         srst,
  // Pins in
  input  wire [W-1:0] din,
  // Settled levels and edges
  output wire [W-1:0] lvl,
  output wire [W-1:0] rise,
  output wire [W-1:0] fall
);

  reg [W-1:0] meta_reg;
  reg [W-1:0] stab_reg;
  reg [W-1:0] prev_reg;

  // ------------------------------------------------------------
  // Only the second stage and its delayed copy feed logic
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      meta_reg <= {W{1'b0}};
      stab_reg <= {W{1'b0}};
      prev_reg <= {W{1'b0}};
    end else begin
      meta_reg <= din;
      stab_reg <= meta_reg;
      prev_reg <= stab_reg;
    end
  end

  assign lvl  = stab_reg;
  assign rise = stab_reg & ~prev_reg;
  assign fall = ~stab_reg & prev_reg;

endmodule // phv_sync

// *** rtl/phv_autozero.v ***
// Sign-bit averaging offset estimator for the encoder input.
// Assumes one update pulse per encoded sample on the same clock.
`timescale 1ns/1ps
`include "phv_defines.vh"

module phv_autozero (
  // Clock and reset
  input  wire       clk,
  input  wire       srst,
  // Encoder sign feedback
  input  wire       upd,
  input  wire       sign_pos,
  // Offset estimate
  output wire [3:0] offset
);

  reg [11:0] acc_reg;

  // ------------------------------------------------------------
  // Saturating up/down average
  // ------------------------------------------------------------
  // Long time constant: offset moves one step per 256 net signs
  always @(posedge clk) begin
    if (srst) begin
      acc_reg <= 12'h000;
    end else if (upd) begin
      if (sign_pos && acc_reg != 12'h7FF) begin
        acc_reg <= acc_reg + 12'h001;
      end else if (!sign_pos && acc_reg != 12'h800) begin
        acc_reg <= acc_reg - 12'h001;
      end
    end
  end

  assign offset = acc_reg[11:`PHV_AZ_SHIFT];

endmodule // phv_autozero

// *** tb/phv_chk.sv ***
// Assertion checker for the PCM highway port, bound to phv_top.
// Assumes an APB master that idles psel for a cycle between transfers.
`timescale 1ns/1ps

module phv_chk (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        srst,
  // APB
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Highway
  input wire logic        tx_frame_strobe,
  input wire logic        pcm_out_oe,
  input wire logic        tx_slot_active_n,
  input wire logic        tx_slot_active_oe,
  input wire logic        rx_signaling_output,
  input wire logic        law_select_neg
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);

  chk_pready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  chk_pready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_err_unmapped: assert property (pready |-> pslverr == (paddr[1:0] != 2'h0 || paddr > 8'h0C))
    else $error("pslverr does not match address map");
  chk_write_data_zero: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("prdata not zero on write");
  chk_slot_pair: assert property (tx_slot_active_oe == pcm_out_oe)
    else $error("slot enable differs from data enable");
  chk_slot_low: assert property (pcm_out_oe |-> !tx_slot_active_n)
    else $error("slot indicator high while driving");
  chk_oe_in_strobe: assert property ($rose(pcm_out_oe) |-> $past(tx_frame_strobe, 3))
    else $error("data driven without frame strobe");
  chk_sig_mu_only: assert property ($changed(rx_signaling_output) |-> !law_select_neg)
    else $error("signaling output moved under a-law");
endmodule // phv_chk

bind phv_top phv_chk phv_chk_inst (
  .ref_clk(ref_clk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tx_frame_strobe(tx_frame_strobe), .pcm_out_oe(pcm_out_oe),
  .tx_slot_active_n(tx_slot_active_n), .tx_slot_active_oe(tx_slot_active_oe),
  .rx_signaling_output(rx_signaling_output), .law_select_neg(law_select_neg)
);

// *** tb/phv_hwy_model.sv ***
// Highway controller model: master clock, bit clock, strobes, data in.
// Assumes the bench calls one frame task at a time.
`timescale 1ns/1ps

module phv_hwy_model (
  // Data from the port
  input  wire logic pcm_out,
  input  wire logic pcm_out_oe,
  // Clocks, strobes and data to the port
  output logic      mclk,
  output logic      bclk,
  output logic      fs_tx,
  output logic      fs_rx,
  output logic      din
);
  // ------------------------------------------------------------
  // Clocks and frames
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    bclk = 1'b0;
    fs_tx = 1'b0;
    fs_rx = 1'b0;
    din = 1'b0;
  end

  // Free-running master clock near 2.048 MHz
  always #244.141 mclk = ~mclk;

  // A floating output reads as z, so a dropped bit never matches
  function automatic logic seen();
    return pcm_out_oe ? pcm_out : 1'bz;
  endfunction

  // Fixed timing: strobe one master period, two for signaling
  task automatic fixed_frame(input logic sig, input logic [7:0] code, output logic [7:0] q);
    @(negedge mclk);
    fs_tx = 1'b1;
    fs_rx = 1'b1;
    for (int k = 0; k < 8; k++) begin
      @(posedge mclk);
      din = code[7-k];
      @(negedge mclk);
      q[7-k] = seen();
      if (k == int'(sig)) begin
        fs_tx = 1'b0;
        fs_rx = 1'b0;
      end
    end
    @(posedge mclk);
    din = ~din;
  endtask

  // Variable timing: bit clock runs only inside the strobe
  task automatic var_frame(input int n, input logic [7:0] code, output logic [15:0] q);
    fs_tx = 1'b1;
    fs_rx = 1'b1;
    #100;
    for (int k = 0; k < n; k++) begin
      #62.5 bclk = 1'b1;
      din = code[7 - k % 8];
      #62.5 bclk = 1'b0;
      q[15-k] = seen();
    end
    #100 fs_tx = 1'b0;
    fs_rx = 1'b0;
    din = ~din;
    // Strobe low long enough for the port to see the next frame start
    #200;
  endtask
endmodule // phv_hwy_model

// *** tb/phv_top_tb.sv ***
// Self-checking bench for the PCM highway port.
// Assumes phv_top, its bound checker and the highway model.
`timescale 1ns/1ps

module phv_top_tb;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  typedef struct {
    logic [7:0]  a;
    logic        w;
    logic [31:0] d;
    logic [3:0]  s;
    logic [31:0] x;
    logic        e;
  } phv_row_t;
  logic        ref_clk, srst, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr, q8;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [15:0] q16;
  logic        mclk, bclk, fs_tx, fs_rx, din, pcm_out, oe, slot_n, slot_oe;
  logic        tx_sig, rx_sig, loop_ctl, law_neg;
  int          fails = 0;
  int          tests_run = 0;
  phv_row_t    rows[8] = '{
    '{8'h00, 1'b0, 32'h0, 4'h0, 32'h3, 1'b0},
    '{8'h04, 1'b0, 32'h0, 4'h0, 32'h0, 1'b0},
    '{8'h04, 1'b1, 32'h5A, 4'h0, 32'h0, 1'b0},
    '{8'h04, 1'b0, 32'h0, 4'h0, 32'h0, 1'b0},
    '{8'h04, 1'b1, 32'h5A, 4'h1, 32'h0, 1'b0},
    '{8'h04, 1'b0, 32'h0, 4'h0, 32'h5A, 1'b0},
    '{8'h10, 1'b0, 32'h0, 4'h0, 32'h0, 1'b1},
    '{8'h0D, 1'b1, 32'h1, 4'h1, 32'h0, 1'b1}};

  phv_top phv_top_inst (
    .ref_clk(ref_clk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_bit_clock(bclk), .rx_bit_clock(bclk), .tx_master_clock(mclk),
    .rx_master_clock(mclk), .tx_frame_strobe(fs_tx), .rx_frame_strobe(fs_rx),
    .pcm_in(din), .pcm_out(pcm_out), .pcm_out_oe(oe), .tx_slot_active_n(slot_n),
    .tx_slot_active_oe(slot_oe), .tx_signaling_input(tx_sig),
    .rx_signaling_output(rx_sig), .loopback_control(loop_ctl), .law_select_neg(law_neg));
  phv_hwy_model phv_hwy_model_inst (
    .pcm_out(pcm_out), .pcm_out_oe(oe), .mclk(mclk), .bclk(bclk),
    .fs_tx(fs_tx), .fs_rx(fs_rx), .din(din));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  always #4 ref_clk = ~ref_clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Holds the request until pready is sampled high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge ref_clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= s;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    {ref_clk, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {srst, tx_sig, loop_ctl, law_neg} = 4'h C;
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    chk(oe, 1'b0, "oe after reset");
    chk(rx_sig, 1'b0, "sig after reset");
    foreach (rows[i]) begin
      apb(rows[i].a, rows[i].w, rows[i].d, rows[i].s);
      chk(rd, rows[i].x, "prdata");
      chk(er, rows[i].e, "pslverr");
    end
    apb(8'h0C, 1'b0, 32'h0, 4'h0);
    chk(rd[2:0], 3'h0, "status modes");
    phv_hwy_model_inst.fixed_frame(1'b0, 8'hA5, q8);
    phv_hwy_model_inst.fixed_frame(1'b0, 8'hA5, q8);
    apb(8'h08, 1'b0, 32'h0, 4'h0);
    chk(rd[7:0], 8'hA5, "rx word");
    apb(8'h04, 1'b1, 32'hC0, 4'h1);
    tx_sig <= 1'b0;
    phv_hwy_model_inst.fixed_frame(1'b0, 8'hA5, q8);
    chk(q8[7], 1'b0, "old sample sign");
    phv_hwy_model_inst.fixed_frame(1'b1, 8'h3B, q8);
    chk(q8[7], 1'b1, "new sample sign");
    chk(q8[0], 1'b0, "tx signaling bit");
    chk(rx_sig, 1'b1, "rx signaling out");
    repeat (5) @(posedge ref_clk);
    chk(oe, 1'b0, "oe after word");
    apb(8'h08, 1'b0, 32'h0, 4'h0);
    chk(rd[7:0], 8'h3A, "rx signaling word");
    law_neg <= 1'b1;
    repeat (2) @(posedge ref_clk);
    apb(8'h0C, 1'b0, 32'h0, 4'h0);
    chk(rd[1], 1'b1, "a-law status");
    phv_hwy_model_inst.fixed_frame(1'b1, 8'h3C, q8);
    chk(q8[7], 1'b0, "a-law sign");
    chk(rx_sig, 1'b1, "no a-law signaling");
    apb(8'h08, 1'b0, 32'h0, 4'h0);
    law_neg <= 1'b0;
    phv_hwy_model_inst.var_frame(16, 8'h96, q16);
    apb(8'h0C, 1'b0, 32'h0, 4'h0);
    chk(rd[0], 1'b1, "variable mode");
    phv_hwy_model_inst.var_frame(16, 8'h96, q16);
    chk(q16[15], 1'b1, "variable sign");
    chk(q16[15:8], q16[7:0], "repeated word");
    chk(rx_sig, 1'b1, "no variable signaling");
    repeat (5) @(posedge ref_clk);
    chk(oe, 1'b0, "oe after strobe");
    apb(8'h08, 1'b0, 32'h0, 4'h0);
    chk(rd[7:0], 8'h96, "variable rx word");
    loop_ctl <= 1'b1;
    repeat (3) phv_hwy_model_inst.var_frame(16, 8'h12, q16);
    chk(q16[15], 1'b0, "loopback sign");
    apb(8'h0C, 1'b0, 32'h0, 4'h0);
    chk(rd[2], 1'b1, "loopback status");
    give_verdict();
  end

  // Whole run needs just under a tenth of this
  initial begin
    #400000;
    fails++;
    give_verdict();
  end
endmodule // phv_top_tb
